// ==== adc_host_model.sv ====
// Host model: a serial master that writes control bytes and collects the result.
// Assumes the bench calls frame and that dout reads as released when its enable is low.
`timescale 1ns/1ps
module adc_host_model (
    // Core clock, used only to pace the link.
    input wire i_core_clk,
    // Serial pins towards the block.
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_din,
    input wire i_dout,
    input wire i_dout_oe,
    input wire i_strobe
);
    // The link clock stands still low between frames.
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_din = 1'b0;
    end
    // Steps whole core cycles and lands just past the edge.
    task automatic wait_c(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    // Sends lz zeros, the byte, then zeros up to fall n after the start bit; 60 core cycles a bit.
    task automatic frame(input logic [7:0] b, input int lz, input int n, output int strb_at, output logic [15:0] res);
        logic [31:0] sr;
        int k;
        sr = 32'h0;
        strb_at = 0;
        o_cs_n = 1'b0;
        wait_c(8);
        for (k = 1 - lz; k <= n; k++) begin
            o_din = (k >= 1 && k <= 8) ? b[8 - k] : 1'b0;
            wait_c(20);
            o_sclk = 1'b1;
            wait_c(20);
            o_sclk = 1'b0;
            wait_c(10);
            // A released line reads as the opposite of its last bit, so a stale value never passes.
            sr = {sr[30:0], i_dout_oe ? i_dout : ~sr[0]};
            if (i_strobe === 1'b1 && strb_at == 0 && k > 0) strb_at = k;
            wait_c(10);
        end
        o_cs_n = 1'b1;
        o_din = ~o_din;
        wait_c(8);
        res = sr[16:1];
    endtask
endmodule // adc_host_model

// ==== adc_serial_control_interface.v ====
// Serial control logic of a 16-bit successive-approximation converter.
// Assumes a host drives the select, serial clock and data pins asynchronously to i_core_clk, and
// that the analog side returns one comparator decision per step on i_cmp_decision.
// Notes on behaviour
// RQ1: Sample serial input on rising clock, select low.
// RQ2: First one bit starts eight-bit control byte.
// RQ3: Zero bits before start are ignored.
// RQ4: Select toggle re-arms start bit detection. A toggle during a control byte is ignored and the byte goes on.
// RQ5: New start bit aborts running conversion.
// RQ6: Output changes on falling edge, off when deselected.
// RQ7: Interface inactive while select is high.
// RQ8: Shutdown input low enters hardware shutdown.
// RQ9: Reset low halts and restores defaults.
// RQ10: Bit five picks conversion clock source.
// RQ11: Bit six picks range and result coding.
// RQ12: Mode 01 calibrates with selected clock.
// RQ13: Host calibrates with conversion clock source.
// RQ14: Bits 0-2 drive user outputs together.
// RQ15: User outputs zero at reset.
// RQ16: User outputs hold during power-down.
// RQ17: Serial clock shifts; external mode also converts.
// RQ18: Short mode strobe after seventh fall.
// RQ19: Long mode strobe after fifteenth fall.
// RQ20: External strobe off when deselected, else low.
// RQ21: External mode ignores clock while deselected.
// RQ22: Internal clock: strobe low converting, high done.
// RQ23: Clock select one internal, zero external.
// RQ24: Mode bits select acquisition, calibrate, power-down.
// RQ25: Range bit one unipolar, zero bipolar.
// RQ26: Result MSB first, binary or two's complement.
`timescale 1ns/1ps
`include "adc_serial_ctrl_map.vh"
module adc_serial_control_interface (
    // Clock and reset.
    input wire i_core_clk,
    input wire i_arst_n,
    // Serial pins from the host.
    input wire i_cs_n,
    input wire i_sclk,
    input wire i_din,
    // Control pins.
    input wire i_hw_powerdown_n,
    input wire i_rst_n,
    // Comparator decision from the analog core for the current bit trial.
    input wire i_cmp_decision,
    // Serial data output as two signals, value and enable.
    output reg o_dout,
    output reg o_dout_oe,
    // Strobe output as two signals, value and enable.
    output reg o_conv_strobe_out,
    output reg o_conv_strobe_out_oe,
    // User outputs.
    output reg o_user_out_bit0,
    output reg o_user_out_bit1,
    output reg o_user_out_bit2,
    // Status towards the analog side.
    output reg o_range_select,
    output reg o_conv_clock_select,
    output reg o_powered_down,
    output reg o_calibrating,
    output reg o_sample_track
);
    localparam ST_IDLE = 3'h0;
    localparam ST_CMD = 3'h1;
    localparam ST_EXT = 3'h2;
    localparam ST_INT_ACQ = 3'h3;
    localparam ST_INT_CONV = 3'h4;
    localparam ST_CAL = 3'h5;

    wire cs_n_s;
    wire sclk_s;
    wire din_s;
    wire pd_n_s;
    wire rst_n_s;
    reg sclk_q;
    reg cs_n_q;
    reg [2:0] state_q;
    reg [6:0] shift_q;
    reg [3:0] bitcnt_q;
    reg [5:0] fall_q;
    reg [4:0] conv_q;
    reg [`RESULT_W-1:0] sar_q;
    reg [`RESULT_W-1:0] result_q;
    reg [3:0] div_q;
    reg [5:0] step_q;
    reg [4:0] out_idx_q;
    reg [1:0] mode_q;
    reg sw_pd_q;
    reg int_done_q;

    // Every pin from the host crosses two flip-flops first.
    sync2 #(.RESET_VAL(1'b1)) u_cs (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_async(i_cs_n), .o_sync(cs_n_s));
    sync2 #(.RESET_VAL(1'b0)) u_sclk (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_async(i_sclk), .o_sync(sclk_s));
    sync2 #(.RESET_VAL(1'b0)) u_din (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_async(i_din), .o_sync(din_s));
    sync2 #(.RESET_VAL(1'b1)) u_pd (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_async(i_hw_powerdown_n),
        .o_sync(pd_n_s));
    sync2 #(.RESET_VAL(1'b0)) u_rst (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_async(i_rst_n), .o_sync(rst_n_s));

    // Edge detection; a deselected interface sees no edges at all.
    wire active = !cs_n_s; // RQ7
    wire rise = active && sclk_s && !sclk_q; // RQ1 RQ21
    wire fall = active && !sclk_s && sclk_q; // RQ6 RQ21
    wire cs_fall = cs_n_q && !cs_n_s;
    wire hw_pd = !pd_n_s; // RQ8
    wire ext_mode = !o_conv_clock_select; // RQ23
    // A one on the data pin outside a byte is a start bit; zeros do nothing.
    wire start_seen = rise && din_s && (state_q != ST_CMD); // RQ2 RQ3 RQ5
    wire [7:0] cbyte = {shift_q, din_s};
    wire [5:0] strb_fall = (mode_q == `MODE_LONG) ? `FALL_STRB_LONG : `FALL_STRB_SHORT; // RQ18 RQ19
    wire int_tick = (div_q == `INT_STEP_DIV);

    // Main sequencer. Reset pin low restores every power-on setting.
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= ST_IDLE;
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            shift_q <= 7'h00;
            bitcnt_q <= 4'h0;
            fall_q <= 6'h00;
            conv_q <= 5'h00;
            sar_q <= {`RESULT_W{1'b0}};
            result_q <= {`RESULT_W{1'b0}};
            div_q <= 4'h0;
            step_q <= 6'h00;
            out_idx_q <= 5'h00;
            mode_q <= `MODE_SHORT;
            sw_pd_q <= 1'b0;
            int_done_q <= 1'b0;
            o_user_out_bit0 <= 1'b0;
            o_user_out_bit1 <= 1'b0;
            o_user_out_bit2 <= 1'b0;
            o_range_select <= 1'b0;
            o_conv_clock_select <= 1'b0;
        end else if (!rst_n_s) begin
            // Halt and return to defaults; user pins go to zero.
            state_q <= ST_IDLE; // RQ9
            sclk_q <= sclk_s;
            cs_n_q <= cs_n_s;
            shift_q <= 7'h00;
            bitcnt_q <= 4'h0;
            fall_q <= 6'h00;
            conv_q <= 5'h00;
            div_q <= 4'h0;
            step_q <= 6'h00;
            out_idx_q <= 5'h00;
            mode_q <= `MODE_SHORT;
            sw_pd_q <= 1'b0;
            int_done_q <= 1'b0;
            o_user_out_bit0 <= 1'b0; // RQ15
            o_user_out_bit1 <= 1'b0; // RQ15
            o_user_out_bit2 <= 1'b0; // RQ15
            o_range_select <= 1'b0;
            o_conv_clock_select <= 1'b0;
        end else begin
            sclk_q <= sclk_s;
            cs_n_q <= cs_n_s;
            div_q <= int_tick ? 4'h0 : div_q + 4'h1;
            if (rise) begin
                shift_q <= {shift_q[5:0], din_s}; // RQ1
            end
            // Shutdown abandons any conversion and returns to idle; user pins keep their value.
            if (hw_pd) begin
                state_q <= ST_IDLE; // RQ8 RQ16
            end else if (cs_fall && state_q != ST_CMD) begin
                // Re-arm start detection; an internal conversion keeps running.
                if (state_q == ST_EXT) begin
                    state_q <= ST_EXT; // RQ4
                end
            end else if (start_seen) begin
                // A fresh start bit abandons whatever was running.
                state_q <= ST_CMD; // RQ2 RQ5
                bitcnt_q <= 4'h1;
                fall_q <= 6'h00;
                int_done_q <= 1'b0;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        state_q <= ST_IDLE; // RQ3
                    end
                    ST_CMD: begin
                        if (rise) begin
                            bitcnt_q <= bitcnt_q + 4'h1;
                            if (bitcnt_q == `CB_BITS - 4'h1) begin
                                // All three user pins update on the same edge.
                                o_user_out_bit0 <= din_s; // RQ14
                                o_user_out_bit1 <= shift_q[0]; // RQ14
                                o_user_out_bit2 <= shift_q[`CB_USER_MSB-1]; // RQ14
                                o_range_select <= cbyte[`CB_RANGE_BIT]; // RQ11 RQ25
                                o_conv_clock_select <= cbyte[`CB_CLKSEL_BIT]; // RQ10 RQ23
                                mode_q <= {cbyte[`CB_MODE_HI_BIT], cbyte[`CB_MODE_LO_BIT]}; // RQ24
                                sw_pd_q <= 1'b0;
                                step_q <= 6'h00;
                                conv_q <= 5'h00;
                                sar_q <= {`RESULT_W{1'b0}};
                                case ({cbyte[`CB_MODE_HI_BIT], cbyte[`CB_MODE_LO_BIT]})
                                    `MODE_PDOWN: begin
                                        sw_pd_q <= 1'b1; // RQ24
                                        state_q <= ST_IDLE;
                                    end
                                    `MODE_CAL: state_q <= ST_CAL; // RQ12
                                    default: state_q <= cbyte[`CB_CLKSEL_BIT] ? ST_INT_ACQ : ST_EXT; // RQ10
                                endcase
                            end
                        end
                        if (fall) begin
                            fall_q <= fall_q + 6'h01;
                        end
                    end
                    ST_EXT: begin
                        // Each serial fall after acquisition is one bit trial.
                        if (fall) begin
                            fall_q <= fall_q + 6'h01; // RQ17
                            if (fall_q >= strb_fall) begin
                                sar_q[`RESULT_W-1-conv_q[3:0]] <= i_cmp_decision;
                                conv_q <= conv_q + 5'h01;
                                out_idx_q <= conv_q;
                                if (conv_q == `CONV_BITS - 5'h01) begin
                                    result_q <= {sar_q[`RESULT_W-1:1], i_cmp_decision};
                                    state_q <= ST_IDLE; // RQ2
                                end
                            end
                        end
                    end
                    ST_INT_ACQ: begin
                        if (int_tick) begin
                            step_q <= step_q + 6'h01;
                            if (step_q == `INT_ACQ_STEPS - 6'h01) begin
                                step_q <= 6'h00;
                                state_q <= ST_INT_CONV;
                            end
                        end
                    end
                    ST_INT_CONV: begin
                        // Own conversion clock, one bit trial per tick.
                        if (int_tick) begin
                            sar_q[`RESULT_W-1-conv_q[3:0]] <= i_cmp_decision; // RQ22
                            conv_q <= conv_q + 5'h01;
                            if (conv_q == `CONV_BITS - 5'h01) begin
                                result_q <= {sar_q[`RESULT_W-1:1], i_cmp_decision};
                                int_done_q <= 1'b1;
                                // Readback presents the MSB on the first serial fall.
                                out_idx_q <= 5'h00;
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_CAL: begin
                        // Calibration paced by whichever clock the byte chose.
                        if ((o_conv_clock_select && int_tick) || (ext_mode && fall)) begin
                            step_q <= step_q + 6'h01; // RQ12
                            if (step_q == `CAL_STEPS - 6'h01) begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
            // Readback of a finished internal result, one bit per serial fall.
            if (fall && int_done_q && state_q == ST_IDLE) begin
                out_idx_q <= out_idx_q + 5'h01;
            end
        end
    end

    // Bit being presented on the data output; MSB first.
    // During an external conversion the trial index marks the MSB for the bipolar inversion.
    wire [3:0] bit_sel = (state_q == ST_EXT) ? conv_q[3:0] : out_idx_q[3:0];
    wire ext_bit = (state_q == ST_EXT) ? i_cmp_decision : result_q[`RESULT_W-1-bit_sel];
    // Bipolar results are two's complement: the converter's offset-binary MSB is inverted.
    wire dout_bit = (bit_sel == 4'h0 && !o_range_select) ? !ext_bit : ext_bit; // RQ26 RQ11
    // The pulse starts on the seventh or fifteenth fall; in short mode that fall comes before the
    // byte is complete, so the clock and mode bits are read from the partial shift register.
    wire cmd_ext_short = (state_q == ST_CMD) && (bitcnt_q == `CB_BITS - 4'h1) && !shift_q[`CB_CLKSEL_BIT-1]
        && ({shift_q[`CB_MODE_HI_BIT-1], shift_q[`CB_MODE_LO_BIT-1]} == `MODE_SHORT); // RQ18
    wire strobe_hit = fall && (cmd_ext_short || ((state_q == ST_EXT) && (fall_q == strb_fall - 6'h01))); // RQ19

    // Pin drivers, all registered; while selected, data and external strobe change only on a serial fall.
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_dout <= 1'b0;
            o_dout_oe <= 1'b0;
            o_conv_strobe_out <= 1'b0;
            o_conv_strobe_out_oe <= 1'b0;
            o_powered_down <= 1'b0;
            o_calibrating <= 1'b0;
            o_sample_track <= 1'b0;
        end else begin
            o_dout_oe <= active; // RQ6
            if (!active) begin
                o_dout <= 1'b0;
            end else if (fall) begin
                o_dout <= dout_bit; // RQ6 RQ26
            end
            if (ext_mode) begin
                // Strobe idles low and is released when deselected.
                o_conv_strobe_out_oe <= active; // RQ20
                if (strobe_hit) begin
                    o_conv_strobe_out <= 1'b1; // RQ18 RQ19
                end else if (fall) begin
                    o_conv_strobe_out <= 1'b0; // RQ20
                end
            end else begin
                o_conv_strobe_out_oe <= 1'b1;
                o_conv_strobe_out <= !(state_q == ST_INT_ACQ || state_q == ST_INT_CONV); // RQ22
            end
            o_powered_down <= hw_pd || sw_pd_q; // RQ8 RQ16
            o_calibrating <= (state_q == ST_CAL);
            o_sample_track <= (state_q == ST_INT_ACQ) || (state_q == ST_EXT && fall_q <= strb_fall);
        end
    end
endmodule // adc_serial_control_interface

// ==== adc_serial_control_interface_bench.sv ====
// Self-checking bench for the converter serial control block.
// Assumes the design header is on the include path and the host model drives the serial pins.
`timescale 1ns/1ps
module adc_serial_control_interface_bench;
    logic i_core_clk, i_arst_n, i_rst_n, i_hw_powerdown_n, cmp;
    wire cs_n, sclk, din, dout, dout_oe, strb, strb_oe, u0, u1, u2, rng, csel, pdn, cal, trk;
    int n_mismatch = 0, check_count = 0, cycles = 0, s, k;
    logic [15:0] r;
    // Core clock of 4 ns.
    always #2 i_core_clk = ~i_core_clk;
    adc_serial_control_interface dut (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_cs_n(cs_n), .i_sclk(sclk),
        .i_din(din), .i_hw_powerdown_n(i_hw_powerdown_n), .i_rst_n(i_rst_n), .i_cmp_decision(cmp), .o_dout(dout),
        .o_dout_oe(dout_oe), .o_conv_strobe_out(strb), .o_conv_strobe_out_oe(strb_oe), .o_user_out_bit0(u0),
        .o_user_out_bit1(u1), .o_user_out_bit2(u2), .o_range_select(rng), .o_conv_clock_select(csel),
        .o_powered_down(pdn), .o_calibrating(cal), .o_sample_track(trk));
    adc_host_model host (.i_core_clk(i_core_clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din), .i_dout(dout),
        .i_dout_oe(dout_oe), .i_strobe(strb && strb_oe));
    // Compare tasks: one for design values, one for counts.
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_num(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            n_mismatch++;
            $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Short mode, unipolar, after leading zeros; comparator always high gives all ones.
    task automatic t_short();
        cmp = 1'b1;
        host.frame(8'hC5, 3, 24, s, r);
        chk_num(s, 7);
        chk_val(r, 16'hFFFF);
        chk_val({u2, u1, u0}, 16'h0005);
        chk_val({rng, csel}, 16'h0002);
    endtask
    // Long mode, bipolar; comparator always low reads back with only the sign bit set.
    task automatic t_long();
        cmp = 1'b0;
        host.frame(8'h9A, 0, 32, s, r);
        chk_num(s, 15);
        chk_val(r, 16'h8000);
        chk_val({u2, u1, u0, rng}, 16'h0004);
    endtask
    // A conversion cut short by a select toggle and a fresh byte restarts cleanly.
    task automatic t_abort();
        cmp = 1'b1;
        host.frame(8'hC5, 0, 12, s, r);
        host.frame(8'hC5, 0, 24, s, r);
        chk_num(s, 7);
        chk_val(r, 16'hFFFF);
    endtask
    // Shutdown pin, then internal clock mode with bipolar readback, software power-down and calibration.
    task automatic t_modes();
        i_hw_powerdown_n = 1'b0;
        host.wait_c(8);
        chk_val({pdn, u2, u1, u0}, 16'h000D);
        i_hw_powerdown_n = 1'b1;
        host.wait_c(8);
        host.frame(8'hA0, 0, 8, s, r);
        chk_val({trk, csel, strb_oe, strb}, 16'h000E);
        for (k = 0; k < 1000 && strb !== 1'b1; k++) host.wait_c(1);
        chk_val(strb, 16'h0001);
        host.frame(8'h00, 0, 17, s, r);
        chk_val(r, 16'h7FFF);
        host.frame(8'hD3, 0, 8, s, r);
        chk_val({pdn, u2, u1, u0}, 16'h000B);
        host.frame(8'hCE, 0, 8, s, r);
        chk_val({cal, csel, u2, u1, u0}, 16'h0016);
    endtask
    // Reset pin clears the outputs and stops calibration.
    task automatic t_rst();
        i_rst_n = 1'b0;
        host.wait_c(8);
        chk_val({cal, rng, csel, u2, u1, u0}, 16'h0000);
        i_rst_n = 1'b1;
        host.wait_c(8);
    endtask
    // A hang ends the run as a mismatch.
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        i_core_clk = 1'b0;
        i_arst_n = 1'b0;
        i_rst_n = 1'b1;
        i_hw_powerdown_n = 1'b1;
        cmp = 1'b0;
        host.wait_c(5);
        i_arst_n = 1'b1;
        host.wait_c(4);
        chk_val({dout_oe, strb_oe, u2, u1, u0}, 16'h0000);
        t_short();
        t_long();
        t_abort();
        t_modes();
        t_rst();
        print_verdict();
    end
endmodule // adc_serial_control_interface_bench

// ==== adc_serial_ctrl_map.vh ====
// Constants for the serial control logic of the 16-bit converter.
// Included by the design files; holds definitions only.
`ifndef ADC_SERIAL_CTRL_MAP_VH
`define ADC_SERIAL_CTRL_MAP_VH
// Control byte field positions.
`define CB_RANGE_BIT 6
`define CB_CLKSEL_BIT 5
`define CB_MODE_HI_BIT 4
`define CB_MODE_LO_BIT 3
`define CB_USER_MSB 2
// Mode codes.
`define MODE_SHORT 2'h0
`define MODE_CAL 2'h1
`define MODE_PDOWN 2'h2
`define MODE_LONG 2'h3
// Serial clock counts.
`define CB_BITS 4'h8
`define FALL_STRB_SHORT 6'h07
`define FALL_STRB_LONG 6'h0F
`define CONV_BITS 5'h10
// Internal conversion clock: divider terminal count; one step every this value plus one core cycles.
`define INT_STEP_DIV 4'h9
`define INT_ACQ_STEPS 6'h08
`define CAL_STEPS 6'h20
`define RESULT_W 16
`endif

// ==== adc_serial_ctrl_monitor.sv ====
// Checker for the converter serial control block, watching its ports only.
// Assumes one core clock domain with an active-low asynchronous reset.
`timescale 1ns/1ps
module adc_serial_ctrl_monitor (
    // Clock, reset and pins in.
    input wire i_core_clk, input wire i_arst_n, input wire i_cs_n, input wire i_sclk,
    input wire i_hw_powerdown_n, input wire i_rst_n,
    // Outputs watched.
    input wire o_dout, input wire o_dout_oe, input wire o_conv_strobe_out, input wire o_conv_strobe_out_oe,
    input wire o_user_out_bit0, input wire o_user_out_bit1, input wire o_user_out_bit2,
    input wire o_range_select, input wire o_conv_clock_select, input wire o_powered_down, input wire o_calibrating
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    // Windows of five or six cycles cover the two-stage input synchronisers and the output register.
    wire [2:0] user_bits = {o_user_out_bit2, o_user_out_bit1, o_user_out_bit0};
    a_dout_off_desel: assert property (i_cs_n [*5] |-> !o_dout_oe)
        else $error("dout driven while deselected");
    a_strb_off_desel: assert property ((i_cs_n && !o_conv_clock_select) [*5] |-> !o_conv_strobe_out_oe)
        else $error("strobe driven while deselected");
    a_user_reset: assert property (!i_rst_n [*5] |-> user_bits == 3'h0)
        else $error("user outputs not cleared by reset pin");
    a_rst_defaults: assert property (!i_rst_n [*5] |-> !o_range_select && !o_conv_clock_select)
        else $error("settings not back to defaults");
    a_hw_powerdown_n_pd: assert property (!i_hw_powerdown_n [*5] |-> o_powered_down)
        else $error("shutdown pin ignored");
    a_user_cs_hold: assert property ((i_cs_n && i_rst_n) [*6] |-> $stable(user_bits))
        else $error("user outputs changed while deselected");
    a_pd_user_hold: assert property ((!i_hw_powerdown_n && i_rst_n) [*6] |-> $stable(user_bits))
        else $error("user outputs changed in shutdown");
    a_strb_pulse: assert property ($rose(o_conv_strobe_out) && !o_conv_clock_select |-> ##[1:60] !o_conv_strobe_out)
        else $error("strobe pulse too long");
    a_dout_fall: assert property (o_dout_oe && $past(o_dout_oe) && $changed(o_dout) |->
        !$past(i_sclk) && !$past(i_sclk, 3))
        else $error("dout changed away from a clock fall");
    c_strobe: cover property ($rose(o_conv_strobe_out));
    c_cal: cover property ($rose(o_calibrating));
    c_pd: cover property ($rose(o_powered_down));
endmodule // adc_serial_ctrl_monitor
bind adc_serial_control_interface adc_serial_ctrl_monitor u_mon (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .i_cs_n(i_cs_n), .i_sclk(i_sclk), .i_hw_powerdown_n(i_hw_powerdown_n), .i_rst_n(i_rst_n), .o_dout(o_dout),
    .o_dout_oe(o_dout_oe), .o_conv_strobe_out(o_conv_strobe_out), .o_conv_strobe_out_oe(o_conv_strobe_out_oe),
    .o_user_out_bit0(o_user_out_bit0), .o_user_out_bit1(o_user_out_bit1), .o_user_out_bit2(o_user_out_bit2),
    .o_range_select(o_range_select), .o_conv_clock_select(o_conv_clock_select),
    .o_powered_down(o_powered_down), .o_calibrating(o_calibrating));

// ==== sync2.v ====
// Two-flip-flop synchroniser for one level from outside the core clock domain.
// Assumes the core clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module sync2 #(
    parameter RESET_VAL = 1'b0
) (
    // Clock and reset.
    input wire i_core_clk,
    input wire i_arst_n,
    // Level in and synchronised level out.
    input wire i_async,
    output reg o_sync
);
    reg meta_q;

    // The first stage feeds only the second stage.
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_q <= RESET_VAL;
            o_sync <= RESET_VAL;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule // sync2
